// [modem_ctrl_pkg.sv]
// constants and state layout for the modem output and power control block
// What this block does
// - qpsk output: reverse low sends I bit first, high sends Q bit first
// - bpsk select high: one bit per symbol, I or Q chosen by reverse bit
// - bpsk discriminator: cross product times sign of dot product
// - qpsk discriminator: cross times dot sign minus dot times cross sign
// - invert bit flips I and Q at serial and parallel data outputs
// - oscillator enable bit ORed with its pin; either one alone can govern
// - oscillator held in reset while its combined enable is low
// - oscillator reset starts on next receive IF tick; registers kept
// - rising transmitter enable bit starts one preamble then data symbols
// - transmit enable ORed with pin; fall resets datapath on next tx tick
// - oscillator, transmitter and receiver enables act independently
// - receiver enable bit ORed with its pin; either one alone can govern
// - receiver re-enable always starts in acquisition mode
// - receiver reset starts on next receive IF tick, lasts six ticks
// - receiver reset clears test point select; host rewrites it later
// - four bit select routes one of 16 test points to 8 bit bus
// - seven power bits, one per nine tap section; high powers down
// - acquisition mode keeps every filter tap powered
// - tap 0 has no power control and is always powered
package modem_ctrl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] ADDR_OUTPUT_FORMAT = 8'h36;
   localparam logic [7:0] ADDR_POWER_ENABLE = 8'h37;
   localparam logic [7:0] ADDR_TEST_SELECT = 8'h38;
   localparam logic [7:0] ADDR_SECTION_POWER = 8'h39;

   // output_format_control fields
   localparam int FMT_REVERSE_BIT = 0;
   localparam int FMT_BPSK_BIT = 1;
   localparam int FMT_INVERT_BIT = 2;
   localparam int FMT_WIDTH = 3;

   // power_enable_control fields
   localparam int EN_OSC_BIT = 0;
   localparam int EN_TX_BIT = 1;
   localparam int EN_RX_BIT = 2;
   localparam int EN_WIDTH = 3;

   localparam int TEST_SEL_WIDTH = 4;
   localparam int TEST_POINTS = 16;
   localparam int SECTIONS = 7;
   localparam int TAPS_PER_SECTION = 9;
   localparam int TAPS = 64;
   localparam int DISC_WIDTH = 17;

   // values after reset
   localparam logic [FMT_WIDTH-1:0] FMT_RESET = 3'h0;
   localparam logic [EN_WIDTH-1:0] EN_RESET = 3'h0;
   localparam logic [TEST_SEL_WIDTH-1:0] TEST_SEL_RESET = 4'h0;
   localparam logic [SECTIONS-1:0] SECTION_POWER_RESET = 7'h00;

   // receiver reset sequence length in receive IF ticks
   localparam logic [2:0] RX_SEQ_TICKS = 3'h6;

   ////////////////////////////////////////////////////////////////////////
   // whole state of the block
   typedef struct packed {
      logic [FMT_WIDTH-1:0] outFmt;
      logic [EN_WIDTH-1:0] enables;
      logic [TEST_SEL_WIDTH-1:0] testSel;
      logic [SECTIONS-1:0] sectionDown;
      logic [7:0] rdData;
      logic oscReset;
      logic txReset;
      logic txBitPrev;
      logic txStart;
      logic rxReset;
      logic rxEffPrev;
      logic rxAcqStart;
      logic [2:0] rxSeqCount;
      logic rxSeqBusy;
      logic serialBit;
      logic serialValid;
      logic pendingBit;
      logic pendingValid;
      logic iOut;
      logic qOut;
      logic parValid;
      logic [DISC_WIDTH-1:0] disc;
      logic [7:0] testBus;
      logic [TAPS-1:0] tapPowered;
   } state_s;

endpackage : modem_ctrl_pkg

// [modem_output_power_control.sv]
// output processor, discriminator, enables, test select and filter power
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module modem_output_power_control
   import modem_ctrl_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   // external enables
   input wire logic oscEnablePin,
   input wire logic txEnablePin,
   input wire logic rxEnablePin,
   // IF clock enables, one mclk cycle each
   input wire logic rxIfTick,
   input wire logic txIfTick,
   // demodulated symbols
   input wire logic symValid,
   input wire logic symI,
   input wire logic symQ,
   input wire logic [DISC_WIDTH-1:0] crossProd,
   input wire logic [DISC_WIDTH-1:0] dotProd,
   // receiver state and test points
   input wire logic acqMode,
   input wire logic [TEST_POINTS*8-1:0] testPoints,
   // receive data outputs
   output logic rxSerialOut,
   output logic rxSerialValid,
   output logic rxIOutA,
   output logic rxQOutB,
   output logic rxParValid,
   // discriminator output
   output logic [DISC_WIDTH-1:0] discOut,
   // test bus
   output logic [7:0] rxTestBus,
   // power control
   output logic oscReset,
   output logic txReset,
   output logic txStart,
   output logic rxReset,
   output logic rxSeqBusy,
   output logic rxAcqStart,
   output logic [TAPS-1:0] tapPowered
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // multiply by +1 or -1 as given by a sign bit
   function automatic logic [DISC_WIDTH-1:0] applySign(
      input logic [DISC_WIDTH-1:0] value,
      input logic sign
   );
      applySign = sign ? DISC_WIDTH'(~value + 1'b1) : value;
   endfunction : applySign

   state_s cur;
   state_s next_cur;

   logic oscEff;
   logic txEff;
   logic rxEff;
   logic rxSeqStart;
   logic firstBit;
   logic secondBit;
   logic [DISC_WIDTH-1:0] crossTerm;
   logic [DISC_WIDTH-1:0] dotTerm;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_cur = cur;

      // each enable is its own bit ORed with its own pin
      oscEff = cur.enables[EN_OSC_BIT] | oscEnablePin;
      txEff = cur.enables[EN_TX_BIT] | txEnablePin;
      rxEff = cur.enables[EN_RX_BIT] | rxEnablePin;
      rxSeqStart = rxIfTick && !rxEff && !cur.rxReset;

      // register writes; unassigned bits are dropped
      if (regWr) begin
         unique case (regAddr)
            ADDR_OUTPUT_FORMAT: next_cur.outFmt = regWrData[FMT_WIDTH-1:0];
            ADDR_POWER_ENABLE: next_cur.enables = regWrData[EN_WIDTH-1:0];
            ADDR_TEST_SELECT: next_cur.testSel = regWrData[TEST_SEL_WIDTH-1:0];
            ADDR_SECTION_POWER: next_cur.sectionDown = regWrData[SECTIONS-1:0];
            default: ;
         endcase
      end

      // read data stands one cycle after the strobe only
      next_cur.rdData = 8'h00;
      if (regRd) begin
         unique case (regAddr)
            ADDR_OUTPUT_FORMAT: next_cur.rdData = {5'h00, cur.outFmt};
            ADDR_POWER_ENABLE: next_cur.rdData = {5'h00, cur.enables};
            ADDR_TEST_SELECT: next_cur.rdData = {4'h0, cur.testSel};
            ADDR_SECTION_POWER: next_cur.rdData = {1'b0, cur.sectionDown};
            default: next_cur.rdData = 8'h00;
         endcase
      end

      ////////////////////////////////////////////////////////////////////
      // oscillator: reset from the receive IF tick after the fall, held
      // until re-enabled; frequency word reload is left to the host
      if (oscEff) begin
         next_cur.oscReset = 1'b0;
      end else if (rxIfTick) begin
         next_cur.oscReset = 1'b1;
      end

      ////////////////////////////////////////////////////////////////////
      // transmitter
      next_cur.txBitPrev = cur.enables[EN_TX_BIT];
      next_cur.txStart = cur.enables[EN_TX_BIT] && !cur.txBitPrev;
      if (txEff) begin
         next_cur.txReset = 1'b0;
      end else if (txIfTick) begin
         next_cur.txReset = 1'b1;
      end

      ////////////////////////////////////////////////////////////////////
      // receiver
      next_cur.rxEffPrev = rxEff;
      next_cur.rxAcqStart = rxEff && !cur.rxEffPrev;
      if (rxEff) begin
         next_cur.rxReset = 1'b0;
      end else if (rxSeqStart) begin
         next_cur.rxReset = 1'b1;
      end
      if (rxSeqStart) begin
         next_cur.rxSeqBusy = 1'b1;
         next_cur.rxSeqCount = RX_SEQ_TICKS - 3'h1;
         // hardware clear wins over a host write in the same cycle
         next_cur.testSel = TEST_SEL_RESET;
      end else if (cur.rxSeqBusy && rxIfTick) begin
         next_cur.rxSeqCount = cur.rxSeqCount - 3'h1;
         if (cur.rxSeqCount == 3'h1) begin
            next_cur.rxSeqBusy = 1'b0;
         end
      end

      ////////////////////////////////////////////////////////////////////
      // output processor
      firstBit = cur.outFmt[FMT_REVERSE_BIT] ? symQ : symI;
      secondBit = cur.outFmt[FMT_REVERSE_BIT] ? symI : symQ;
      next_cur.serialValid = 1'b0;
      next_cur.parValid = 1'b0;
      if (symValid) begin
         // a new symbol drops a second bit not yet sent
         next_cur.serialBit = firstBit ^ cur.outFmt[FMT_INVERT_BIT];
         next_cur.serialValid = 1'b1;
         next_cur.pendingBit = secondBit ^ cur.outFmt[FMT_INVERT_BIT];
         next_cur.pendingValid = !cur.outFmt[FMT_BPSK_BIT];
         next_cur.iOut = symI ^ cur.outFmt[FMT_INVERT_BIT];
         next_cur.qOut = symQ ^ cur.outFmt[FMT_INVERT_BIT];
         next_cur.parValid = 1'b1;
      end else if (cur.pendingValid) begin
         next_cur.serialBit = cur.pendingBit;
         next_cur.serialValid = 1'b1;
         next_cur.pendingValid = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////
      // frequency discriminator, sign bits act as +1 or -1
      crossTerm = applySign(crossProd, dotProd[DISC_WIDTH-1]);
      dotTerm = applySign(dotProd, crossProd[DISC_WIDTH-1]);
      if (cur.outFmt[FMT_BPSK_BIT]) begin
         next_cur.disc = crossTerm;
      end else begin
         next_cur.disc = DISC_WIDTH'(crossTerm - dotTerm);
      end

      ////////////////////////////////////////////////////////////////////
      // test bus and filter power
      next_cur.testBus = testPoints[cur.testSel*8 +: 8];
      next_cur.tapPowered[0] = 1'b1;
      for (int s = 0; s < SECTIONS; s++) begin
         for (int t = 0; t < TAPS_PER_SECTION; t++) begin
            // acquisition needs the full filter
            next_cur.tapPowered[1 + s*TAPS_PER_SECTION + t] =
               acqMode || !cur.sectionDown[s];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cur <= '0;
         cur.outFmt <= FMT_RESET;
         cur.enables <= EN_RESET;
         cur.testSel <= TEST_SEL_RESET;
         cur.sectionDown <= SECTION_POWER_RESET;
         // datapaths start held until an enable rises
         cur.oscReset <= 1'b1;
         cur.txReset <= 1'b1;
         cur.rxReset <= 1'b1;
         cur.tapPowered <= '1;
      end else begin
         cur <= next_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign regRdData = cur.rdData;
   assign rxSerialOut = cur.serialBit;
   assign rxSerialValid = cur.serialValid;
   assign rxIOutA = cur.iOut;
   assign rxQOutB = cur.qOut;
   assign rxParValid = cur.parValid;
   assign discOut = cur.disc;
   assign rxTestBus = cur.testBus;
   assign oscReset = cur.oscReset;
   assign txReset = cur.txReset;
   assign txStart = cur.txStart;
   assign rxReset = cur.rxReset;
   assign rxSeqBusy = cur.rxSeqBusy;
   assign rxAcqStart = cur.rxAcqStart;
   assign tapPowered = cur.tapPowered;

endmodule : modem_output_power_control

// [modem_output_power_control_chk.sv]
// port assertions for the modem output and power control block
`timescale 1ns/100ps
module modem_output_power_control_chk
   import modem_ctrl_pkg::*;
(
   // clock, reset and bus
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] regAddr,
   input wire logic regRd,
   input wire logic [7:0] regRdData,
   // enables
   input wire logic oscEnablePin,
   input wire logic rxEnablePin,
   input wire logic rxIfTick,
   input wire logic oscReset,
   input wire logic rxReset,
   input wire logic rxSeqBusy,
   // data and filter
   input wire logic symValid,
   input wire logic rxSerialValid,
   input wire logic rxParValid,
   input wire logic acqMode,
   input wire logic [TAPS-1:0] tapPowered
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic [2:0] seqTicks;
   // start tick already counted when busy rises
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) seqTicks <= 3'h1;
      else if (!rxSeqBusy) seqTicks <= 3'h1;
      else if (rxIfTick) seqTicks <= seqTicks + 3'h1;
   end
   ////////////////////////////////////////////////////////////
   property p_rdUnmapped; regRd && regAddr == 8'h3C |=> regRdData == 8'h00; endproperty
   a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");
   property p_tapZero; tapPowered[0]; endproperty
   a_tapZero: assert property (p_tapZero) else $error("tap zero unpowered");
   property p_acqAll; acqMode |=> &tapPowered; endproperty
   a_acqAll: assert property (p_acqAll) else $error("tap off in acquisition");
   property p_parPulse; symValid |=> rxParValid; endproperty
   a_parPulse: assert property (p_parPulse) else $error("no parallel valid");
   property p_serPulse; symValid |=> rxSerialValid; endproperty
   a_serPulse: assert property (p_serPulse) else $error("no serial valid");
   property p_seqLen; $fell(rxSeqBusy) |-> seqTicks == 3'h6; endproperty
   a_seqLen: assert property (p_seqLen) else $error("sequence length wrong");
   property p_seqStart; $rose(rxSeqBusy) |-> $past(rxIfTick) && rxReset; endproperty
   a_seqStart: assert property (p_seqStart) else $error("sequence start wrong");
   property p_oscPin; oscEnablePin |=> !oscReset; endproperty
   a_oscPin: assert property (p_oscPin) else $error("pin does not free osc");
   property p_rxPin; rxEnablePin |=> !rxReset; endproperty
   a_rxPin: assert property (p_rxPin) else $error("pin does not free rx");
   c_seqDone: cover property ($fell(rxSeqBusy));
   c_sym: cover property (symValid ##1 rxParValid);
   c_acq: cover property ($rose(acqMode));
endmodule : modem_output_power_control_chk
bind modem_output_power_control modem_output_power_control_chk
   modem_output_power_control_chk_inst (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
   .regRd(regRd), .regRdData(regRdData), .oscEnablePin(oscEnablePin),
   .rxEnablePin(rxEnablePin), .rxIfTick(rxIfTick), .oscReset(oscReset),
   .rxReset(rxReset), .rxSeqBusy(rxSeqBusy), .symValid(symValid),
   .rxSerialValid(rxSerialValid), .rxParValid(rxParValid), .acqMode(acqMode),
   .tapPowered(tapPowered));

// [host_model.sv]
// host processor model driving the register port
`timescale 1ns/100ps
module host_model (
   // clock
   input wire logic mclk,
   // register port
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   output logic regWr,
   output logic regRd,
   input wire logic [7:0] regRdData
);
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   ////////////////////////////////////////
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      v = regRdData;
   endtask : rd
endmodule : host_model

// [modem_output_power_control_tb_top.sv]
// self-checking bench for the modem output and power control block
`timescale 1ns/100ps
module modem_output_power_control_tb_top;
   import modem_ctrl_pkg::*;
   logic mclk, rstn, oscPin, txPin, rxPin, rxTick, txTick, symV, symI, symQ, acq;
   logic [16:0] crossVal, dot, disc;
   logic [127:0] tp;
   logic [7:0] regAddr, regWrData, regRdData, rx_test_bus, d;
   logic regWr, regRd, so, sv, io, qo, pv, oscR, txR, txS, rxR, busy, acqS;
   logic [63:0] tap, e;
   int n_errors = 0, n_compared = 0, n;
   always #50 mclk = ~mclk;
   host_model host_model_inst (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
   modem_output_power_control modem_output_power_control_inst (.mclk(mclk), .rstn(rstn),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .oscEnablePin(oscPin), .txEnablePin(txPin), .rxEnablePin(rxPin),
      .rxIfTick(rxTick), .txIfTick(txTick), .symValid(symV), .symI(symI), .symQ(symQ),
      .crossProd(crossVal), .dotProd(dot), .acqMode(acq), .testPoints(tp), .rxSerialOut(so),
      .rxSerialValid(sv), .rxIOutA(io), .rxQOutB(qo), .rxParValid(pv), .discOut(disc),
      .rxTestBus(rx_test_bus), .oscReset(oscR), .txReset(txR), .txStart(txS), .rxReset(rxR),
      .rxSeqBusy(busy), .rxAcqStart(acqS), .tapPowered(tap));
   ////////////////////////////////////////
   task chk(input string s, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   task results;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task step;
      @(posedge mclk);
      #1;
   endtask : step
   task tick;
      @(posedge mclk);
      rxTick <= 1'b1;
      @(posedge mclk);
      rxTick <= 1'b0;
      #1;
   endtask : tick
   ////////////////////////////////////////
   task t_power;
      @(posedge mclk);
      acq <= 1'b0;
      host_model_inst.wr(8'h39, 8'hC1); // coefficients of those sections are zero
      host_model_inst.rd(8'h39, d);
      chk("power", d, 8'h41);
      e = '1;
      for (int t = 1; t < 64; t++) e[t] = !((t - 1) / 9 inside {0, 6});
      chk("taps", tap, e);
      @(posedge mclk);
      acq <= 1'b1;
      step;
      step;
      chk("acq taps", tap, '1);
      host_model_inst.rd(8'h3C, d);
      chk("unmapped", d, 8'h00);
   endtask : t_power
   task t_fmt;
      logic [2:0] f;
      for (int k = 0; k < 8; k++) begin
         f = 3'(k);
         host_model_inst.wr(8'h36, {5'h00, f});
         @(posedge mclk);
         symV <= 1'b1;
         @(posedge mclk);
         symV <= 1'b0;
         #1;
         chk("first", {sv, so}, {1'b1, ~f[0] ^ f[2]});
         chk("par", {pv, io, qo}, {1'b1, ~f[2], f[2]});
         chk("disc", disc, f[1] ? 17'h1fffb : 17'h1fffe);
         step;
         chk("second", {sv, so & ~f[1]}, {~f[1], (f[0] ^ f[2]) & ~f[1]});
      end
   endtask : t_fmt
   task t_test;
      for (int k = 0; k < 16; k++) begin
         host_model_inst.wr(8'h38, 8'(k));
         step;
         chk("test bus", rx_test_bus, tp[8*k+:8]);
      end
   endtask : t_test
   task t_enables;
      host_model_inst.wr(8'h37, 8'h04);
      step;
      chk("rx on", {rxR, acqS}, 2'b01);
      host_model_inst.wr(8'h38, 8'h05);
      host_model_inst.wr(8'h37, 8'h00);
      step;
      chk("rx waits", rxR, 1'b0);
      tick;
      chk("rx seq", {rxR, busy}, 2'b11);
      host_model_inst.rd(8'h38, d);
      chk("sel clear", d, 8'h00);
      n = 1;
      while (busy === 1'b1 && n < 12) begin
         tick;
         n++;
      end
      chk("seq ticks", n, 6);
      host_model_inst.rd(8'h36, d);
      chk("fmt kept", d, 8'h07);
      @(posedge mclk);
      oscPin <= 1'b1;
      @(posedge mclk);
      oscPin <= 1'b0;
      #1;
      chk("osc pin", oscR, 1'b0);
      step;
      chk("osc waits", oscR, 1'b0);
      tick;
      chk("osc off", oscR, 1'b1);
      host_model_inst.wr(8'h37, 8'h01);
      host_model_inst.wr(8'h00, 8'h01); // frequency word reload
      step;
      chk("osc bit", {oscR, rxR}, 2'b01);
      host_model_inst.wr(8'h37, 8'h03);
      step;
      chk("tx start", {txS, txR}, 2'b10);
      @(posedge mclk);
      txPin <= 1'b1;
      host_model_inst.wr(8'h37, 8'h01); // burst done
      txTick <= 1'b1;
      @(posedge mclk);
      txTick <= 1'b0;
      #1;
      chk("tx pin", {txS, txR}, 2'b00);
      @(posedge mclk);
      txPin <= 1'b0;
      step;
      chk("tx waits", txR, 1'b0);
      @(posedge mclk);
      txTick <= 1'b1;
      @(posedge mclk);
      txTick <= 1'b0;
      #1;
      chk("tx off", {txR, oscR}, 2'b10);
      @(posedge mclk);
      rxPin <= 1'b1;
      step;
      chk("rx pin", {rxR, acqS}, 2'b01);
   endtask : t_enables
   ////////////////////////////////////////
   initial begin
      {mclk, rstn, oscPin, txPin, rxPin, rxTick, txTick, symV, symQ} = '0;
      {symI, acq} = 2'b11;
      crossVal = 17'h0_0005;
      dot = 17'h1_fffd;
      for (int k = 0; k < 16; k++) tp[8*k+:8] = {4'(k), 4'(15 - k)};
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      t_power;
      t_fmt;
      t_test;
      t_enables;
      results;
   end
   // whole run is well under two thousand cycles
   initial begin
      #2_000_000;
      n_errors++;
      results;
   end
endmodule : modem_output_power_control_tb_top
